/* logic/sccc_ctrl.sv */
// system-clock side: command decode, internal conversions, result fifo and end of conversion
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - External mode: command byte starts sclk-timed conversion
// - External mode: no scan/average, result shifts live
// - External mode: temperature result in final two bytes, after 22 zero bytes
// - Short first byte: next byte continues, rest lost
// - Short second byte: rest of entry lost
// - Other entries survive; host ignores lead nibble
// - Cut-short write changes received msbs only
// - Select before end-of-conversion aborts, corrupts fifo
// - Conversion code straight binary, 1024 steps
// - Temperature code binary, eighth-degree steps
// - End-of-conversion low until select falls
// - Power-up clock mode is internal serial
module sccc_ctrl #(
    parameter int FIFO_DEPTH = 16,
    parameter int CONV_CYC = 16,
    parameter int TEMP_CYC = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic [9:0] conv_code,
    input wire logic [11:0] temp_code,
    output logic dout,
    output logic eoc_n,
    output logic [3:0] chan_sel
);
    localparam int PW = $clog2(FIFO_DEPTH);

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAKE = 4'h2,
        ST_MEAS = 4'h4,
        ST_SPARE = 4'h8
    } sccc_state_t;

    sccc_pkg::sccc_rx_t rx_w;
    logic byte_tgl_w, load_tgl_w, frame_tgl_w;
    logic ext_reg, ext_next;
    sccc_pkg::sccc_tx_t tx_reg, tx_next;

    sccc_link u_link (
        .sclk(sclk),
        .rst(rst),
        .cs_n(cs_n),
        .din(din),
        .ext_mode(ext_reg),
        .conv_code(conv_code),
        .temp_code(temp_code),
        .tx(tx_reg),
        .dout(dout),
        .rx(rx_w),
        .byte_tgl(byte_tgl_w),
        .load_tgl(load_tgl_w),
        .frame_tgl(frame_tgl_w)
    );

    // three-flop synchronisers: 0 chip select, 1 byte, 2 entry load, 3 frame start
    logic [3:0] async_in;
    logic [2:0] sync_reg [4];
    logic [2:0] sync_next [4];
    logic [3:0] lvl_reg, lvl_next, ev_reg, ev_next;

    assign async_in = {frame_tgl_w, load_tgl_w, byte_tgl_w, cs_n};

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sync_next[i] = {sync_reg[i][1:0], async_in[i]};
            lvl_next[i] = (sync_reg[i][1] == sync_reg[i][2]) ? sync_reg[i][2] : lvl_reg[i];
        end
        ev_next = lvl_next ^ lvl_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_reg[0] <= 3'h7;
            for (int i = 1; i < 4; i++) begin
                sync_reg[i] <= 3'h0;
            end
            lvl_reg <= 4'h1;
            ev_reg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                sync_reg[i] <= sync_next[i];
            end
            lvl_reg <= lvl_next;
            ev_reg <= ev_next;
        end
    end

    logic cs_fall, cs_rise, byte_evt, load_evt, frame_evt;
    assign cs_fall = ev_reg[0] & ~lvl_reg[0];
    assign cs_rise = ev_reg[0] & lvl_reg[0];
    assign byte_evt = ev_reg[1];
    assign load_evt = ev_reg[2];
    assign frame_evt = ev_reg[3];

    // core state
    logic [7:0] setup_reg, setup_next, conv_reg, conv_next, mw;
    sccc_state_t state_reg, state_next;
    logic [15:0] timer_reg, timer_next;
    logic temp_pend_reg, temp_pend_next;
    logic eoc_n_reg, eoc_n_next;
    logic seen_reg, seen_next;
    logic [15:0] fifo_reg [FIFO_DEPTH];
    logic [15:0] fifo_next [FIFO_DEPTH];
    logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [PW:0] cnt_reg, cnt_next;
    logic push, pop, flush, start_evt, wake_need, pw_setup;
    logic [15:0] push_word;
    logic [7:0] cmd;

    assign cmd = rx_w.cmd;
    assign start_evt = byte_evt && cmd[sccc_pkg::CMD_CONV_BIT]
        && setup_reg[sccc_pkg::CKSEL_LSB +: 2] == sccc_pkg::CKSEL_INT_SERIAL;
    assign wake_need = cmd[sccc_pkg::CMD_TEMP_BIT]
        || setup_reg[sccc_pkg::REFSEL_LSB +: 2] == sccc_pkg::REF_NEEDS_WAKE;
    assign mw = sccc_pkg::merge_msb(setup_reg, rx_w.part, rx_w.nbits);
    assign pw_setup = cs_rise && seen_reg && rx_w.nbits >= 3'h2 && mw[7:6] == sccc_pkg::SETUP_SEL;

    always_comb begin
        setup_next = setup_reg;
        conv_next = conv_reg;
        state_next = state_reg;
        timer_next = timer_reg;
        temp_pend_next = temp_pend_reg;
        eoc_n_next = eoc_n_reg;
        seen_next = seen_reg | frame_evt;
        fifo_next = fifo_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        push = 1'b0;
        flush = 1'b0;
        push_word = 16'h0;
        case (state_reg)
            ST_IDLE: begin
            end
            ST_WAKE: begin
                if (timer_reg == 16'h0) begin
                    state_next = ST_MEAS;
                    timer_next = temp_pend_reg ? 16'(TEMP_CYC - 1) : 16'(CONV_CYC - 1);
                end else begin
                    timer_next = timer_reg - 16'h1;
                end
            end
            ST_MEAS: begin
                if (timer_reg == 16'h0) begin
                    push = 1'b1;
                    if (temp_pend_reg) begin
                        // temperature result goes ahead of the conversion result
                        push_word = sccc_pkg::fmt_temp(temp_code);
                        temp_pend_next = 1'b0;
                        timer_next = 16'(CONV_CYC - 1);
                    end else begin
                        push_word = sccc_pkg::fmt_conv(conv_code);
                        state_next = ST_IDLE;
                        eoc_n_next = 1'b0;
                    end
                end else begin
                    timer_next = timer_reg - 16'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (byte_evt) begin
            if (cmd[sccc_pkg::CMD_CONV_BIT]) begin
                conv_next = cmd;
                if (start_evt) begin
                    eoc_n_next = 1'b1;
                    temp_pend_next = cmd[sccc_pkg::CMD_TEMP_BIT];
                    state_next = wake_need ? ST_WAKE : ST_MEAS;
                    timer_next = wake_need ? 16'(sccc_pkg::REF_WAKE_CYC - 1)
                        : (cmd[sccc_pkg::CMD_TEMP_BIT] ? 16'(TEMP_CYC - 1) : 16'(CONV_CYC - 1));
                end
            end else if (cmd[7:6] == sccc_pkg::SETUP_SEL) begin
                setup_next = cmd;
            end else if (cmd[7:4] == sccc_pkg::RESET_SEL) begin
                flush = 1'b1;
                if (!cmd[sccc_pkg::RESET_FIFO_BIT]) begin
                    setup_next = sccc_pkg::SETUP_RST;
                    conv_next = sccc_pkg::CONV_RST;
                end
            end
        end
        if (cs_rise) begin
            seen_next = 1'b0;
            if (pw_setup) begin
                setup_next = mw;
            end
        end
        if (cs_fall) begin
            eoc_n_next = 1'b1;
            if (state_reg != ST_IDLE) begin
                state_next = ST_IDLE;
                temp_pend_next = 1'b0;
                flush = 1'b1;
            end
        end
        pop = load_evt && cnt_reg != '0;
        if (flush) begin
            wr_next = '0;
            rd_next = '0;
            cnt_next = '0;
        end else begin
            if (push && cnt_reg != (PW + 1)'(FIFO_DEPTH)) begin
                fifo_next[wr_reg] = push_word;
                wr_next = wr_reg + 1'b1;
                cnt_next = cnt_next + 1'b1;
            end
            if (pop) begin
                rd_next = rd_reg + 1'b1;
                cnt_next = cnt_next - 1'b1;
            end
        end
        tx_next.valid = cnt_next != '0;
        tx_next.word = tx_next.valid ? fifo_next[rd_next] : 16'h0;
        ext_next = setup_next[sccc_pkg::CKSEL_LSB +: 2] == sccc_pkg::CKSEL_EXT;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setup_reg <= sccc_pkg::SETUP_RST;
            conv_reg <= sccc_pkg::CONV_RST;
            state_reg <= ST_IDLE;
            timer_reg <= 16'h0;
            temp_pend_reg <= 1'b0;
            eoc_n_reg <= 1'b1;
            seen_reg <= 1'b0;
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                fifo_reg[i] <= 16'h0;
            end
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            tx_reg <= '0;
            ext_reg <= 1'b0;
        end else begin
            setup_reg <= setup_next;
            conv_reg <= conv_next;
            state_reg <= state_next;
            timer_reg <= timer_next;
            temp_pend_reg <= temp_pend_next;
            eoc_n_reg <= eoc_n_next;
            seen_reg <= seen_next;
            fifo_reg <= fifo_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
            tx_reg <= tx_next;
            ext_reg <= ext_next;
        end
    end

    assign eoc_n = eoc_n_reg;
    assign chan_sel = conv_reg[sccc_pkg::CHSEL_LSB +: 4];

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wake_start;
        start_evt && wake_need && !cs_fall;
    endsequence

    a_reset_mode_ok: assert property ($past(rst) |-> setup_reg[5:4] == sccc_pkg::CKSEL_INT_SERIAL)
        else $error("clock mode after reset is not internal serial");
    a_eoc_hold_low: assert property (!eoc_n_reg && !cs_fall && !start_evt |=> !eoc_n_reg)
        else $error("end of conversion released without select falling");
    a_eoc_release: assert property (cs_fall |=> eoc_n_reg)
        else $error("end of conversion still low after select fell");
    a_early_abort: assert property (cs_fall && state_reg != ST_IDLE |=> state_reg == ST_IDLE && cnt_reg == '0)
        else $error("early select did not abort and flush");
    a_partial_keep: assert property (pw_setup && rx_w.nbits == 3'h4 |=> setup_reg[3:0] == $past(setup_reg[3:0]))
        else $error("unwritten setup bits changed on partial write");
    a_ref_wake_wait: assert property (s_wake_start |=> (state_reg == ST_WAKE)[*8])
        else $error("reference wake shorter than expected");
    a_fifo_pop_one: assert property (load_evt && cnt_reg != '0 && !push && !flush |=> cnt_reg == $past(cnt_reg) - 1'b1)
        else $error("entry load did not remove exactly one entry");
    a_ext_no_scan: assert property (byte_evt && cmd[7] && ext_reg && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
        else $error("internal sequence started in external clock mode");
endmodule
`default_nettype wire

/* logic/sccc_link.sv */
// serial-clock side: shifting, frame byte counting and externally clocked conversions
`timescale 1ns/1ps
`default_nettype none
module sccc_link (
    input wire logic sclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic din,
    input wire logic ext_mode,
    input wire logic [9:0] conv_code,
    input wire logic [11:0] temp_code,
    input wire sccc_pkg::sccc_tx_t tx,
    output logic dout,
    output var sccc_pkg::sccc_rx_t rx,
    output logic byte_tgl,
    output logic load_tgl,
    output logic frame_tgl
);
    logic first_reg;
    logic [2:0] cnt_reg, cnt_next, c;
    logic [7:0] sh_reg, sh_next, cmd_reg, cmd_next;
    logic [15:0] ent_sh_reg, ent_sh_next, w;
    logic ent_left_reg, ent_left_next;
    logic [7:0] cv_cnt_reg, cv_cnt_next;
    logic [15:0] cv_sh_reg, cv_sh_next;
    logic dout_reg, dout_next;
    logic byte_reg, byte_next, load_reg, load_next, frame_reg, frame_next;
    logic cv_msb;

    // frame start marker, set while chip select is high
    always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
        if (rst || cs_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    always_comb begin
        c = first_reg ? 3'h0 : cnt_reg;
        w = ent_sh_reg;
        cnt_next = c + 3'h1;
        sh_next = {sh_reg[6:0], din};
        cmd_next = cmd_reg;
        ent_sh_next = ent_sh_reg;
        ent_left_next = ent_left_reg;
        cv_cnt_next = cv_cnt_reg;
        cv_sh_next = cv_sh_reg;
        dout_next = dout_reg;
        byte_next = byte_reg;
        load_next = load_reg;
        frame_next = frame_reg ^ first_reg;
        if (cv_cnt_reg != 8'h0) begin
            cv_cnt_next = cv_cnt_reg - 8'h1;
            if (cv_cnt_reg <= sccc_pkg::OUT_SCLKS) begin
                dout_next = cv_sh_reg[15];
                cv_sh_next = {cv_sh_reg[14:0], 1'b0};
            end else begin
                dout_next = 1'b0;
            end
        end else begin
            if (c == 3'h0) begin
                if (!ent_left_reg) begin
                    w = tx.word;
                    ent_left_next = tx.valid;
                    load_next = load_reg ^ tx.valid;
                end else begin
                    // second byte of an entry, whole or cut short before: the following bits go out, then it ends
                    ent_left_next = 1'b0;
                end
            end
            dout_next = w[15];
            ent_sh_next = {w[14:0], 1'b0};
        end
        if (c == 3'h7) begin
            cmd_next = sh_next;
            byte_next = ~byte_reg;
            // a command on the last clock of a conversion chains the next one
            if (ext_mode && sh_next[sccc_pkg::CMD_CONV_BIT] && cv_cnt_reg <= 8'h1) begin
                if (sh_next[sccc_pkg::CMD_TEMP_BIT]) begin
                    cv_cnt_next = sccc_pkg::TEMP_SCLKS;
                    cv_sh_next = sccc_pkg::fmt_temp(temp_code);
                end else begin
                    cv_cnt_next = sccc_pkg::CONV_SCLKS;
                    cv_sh_next = sccc_pkg::fmt_conv(conv_code);
                end
            end
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 3'h0;
            sh_reg <= 8'h0;
            cmd_reg <= 8'h0;
            ent_sh_reg <= 16'h0;
            ent_left_reg <= 1'b0;
            cv_cnt_reg <= 8'h0;
            cv_sh_reg <= 16'h0;
            dout_reg <= 1'b0;
            byte_reg <= 1'b0;
            load_reg <= 1'b0;
            frame_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            cmd_reg <= cmd_next;
            ent_sh_reg <= ent_sh_next;
            ent_left_reg <= ent_left_next;
            cv_cnt_reg <= cv_cnt_next;
            cv_sh_reg <= cv_sh_next;
            dout_reg <= dout_next;
            byte_reg <= byte_next;
            load_reg <= load_next;
            frame_reg <= frame_next;
        end
    end

    assign dout = dout_reg;
    assign rx = {cmd_reg, sh_reg, cnt_reg};
    assign byte_tgl = byte_reg;
    assign load_tgl = load_reg;
    assign frame_tgl = frame_reg;
    assign cv_msb = cv_sh_reg[15];

    default clocking @(posedge sclk); endclocking
    default disable iff (rst || cs_n);

    sequence s_out_start;
        cv_cnt_reg == sccc_pkg::OUT_SCLKS;
    endsequence

    a_temp_lead_zero: assert property ((cv_cnt_reg > sccc_pkg::OUT_SCLKS) |=> !dout_reg)
        else $error("dout not zero during temperature lead-in");
    a_conv_sclk_len: assert property ((cv_cnt_reg == 8'h10) |=> (cv_cnt_reg == 8'h0f) ##14 (cv_cnt_reg == 8'h01))
        else $error("conversion did not last sixteen serial clocks");
    a_result_msb_out: assert property (s_out_start |=> dout_reg == $past(cv_msb))
        else $error("result msb not first on dout");
endmodule
`default_nettype wire

/* shared/sccc_pkg.sv */
// package: constants, carriers and helpers for the serial conversion controller
package sccc_pkg;
    // clock mode field of the setup byte
    localparam logic [1:0] CKSEL_INT_SERIAL = 2'h2;
    localparam logic [1:0] CKSEL_EXT = 2'h3;
    localparam int CKSEL_LSB = 4;
    // reference mode field of the setup byte
    localparam logic [1:0] REF_NEEDS_WAKE = 2'h0;
    localparam int REFSEL_LSB = 2;
    // command byte decode
    localparam int CMD_CONV_BIT = 7;
    localparam int CMD_TEMP_BIT = 0;
    localparam int CHSEL_LSB = 3;
    localparam logic [1:0] SETUP_SEL = 2'h1;
    localparam logic [3:0] RESET_SEL = 4'h1;
    localparam int RESET_FIFO_BIT = 3;
    // reset values
    localparam logic [7:0] SETUP_RST = 8'h60;
    localparam logic [7:0] CONV_RST = 8'h80;
    // serial clock counts of the externally clocked mode
    localparam logic [7:0] CONV_SCLKS = 8'h10;
    localparam logic [7:0] TEMP_SCLKS = 8'hc0;
    localparam logic [7:0] OUT_SCLKS = 8'h10;
    // reference wake time in system clocks, rounded up
    localparam int CLK_NS = 40;
    localparam int REF_WAKE_US = 65;
    localparam int REF_WAKE_CYC = (REF_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] part;
        logic [2:0] nbits;
    } sccc_rx_t;

    typedef struct packed {
        logic [15:0] word;
        logic valid;
    } sccc_tx_t;

    // four zero lead bits, 10-bit straight binary code, two zero tail bits
    function automatic logic [15:0] fmt_conv(input logic [9:0] code);
        return {4'h0, code, 2'h0};
    endfunction

    // four zero lead bits, 12-bit code in eighth-degree steps
    function automatic logic [15:0] fmt_temp(input logic [11:0] code);
        return {4'h0, code};
    endfunction

    // top n bits from the cut-short byte, the rest kept from the old value
    function automatic logic [7:0] merge_msb(input logic [7:0] old, input logic [7:0] part, input logic [2:0] n);
        logic [3:0] sh;
        logic [7:0] mask;
        sh = 4'h8 - {1'b0, n};
        mask = 8'hff << sh;
        return ((part << sh) & mask) | (old & ~mask);
    endfunction
endpackage

/* testbench/sccc_host.sv */
// behavioural host serial master for the conversion controller
`timescale 1ns/1ps
`default_nettype none
module sccc_host (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    output logic [7:0] got,
    output logic got_stb
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        got = 8'h00;
        got_stb = 1'b0;
    end

    // sends nbits msb first from the left-aligned head, zeros after it; every whole byte read back is posted on got
    task automatic frame(input logic [39:0] head, input int nbits);
        logic [7:0] sh;
        sh = 8'h00;
        cs_n = 1'b0;
        #32;
        for (int i = 0; i < nbits; i++) begin
            din = (i < 40) ? head[39 - i] : 1'b0;
            #32 sclk = 1'b1;
            #31 sh = {sh[6:0], dout};
            #1 sclk = 1'b0;
            if (i % 8 == 7) begin
                got = sh;
                got_stb = 1'b1;
                #1 got_stb = 1'b0;
            end
        end
        // released line shows the inverse of its last level
        din = ~din;
        #32 cs_n = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

/* testbench/serial_clocked_conversion_ctrl_test.sv */
// testbench: conversion controller driven by a behavioural host
`timescale 1ns/1ps
`default_nettype none
module serial_clocked_conversion_ctrl_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] conv_code;
    logic [11:0] temp_code;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic eoc_n;
    logic got_stb;
    logic [3:0] chan_sel;
    logic [7:0] got;
    logic [8:0] exq[$];
    logic [8:0] e;
    logic [31:0] seed = 32'h0000003a;
    logic [15:0] wt;
    logic [15:0] wc;
    int fail_count = 0;
    int comparisons = 0;
    int n;

    always #20 clk = ~clk;

    sccc_ctrl dut (.clk(clk), .rst(rst), .sclk(sclk),
        .cs_n(cs_n), .din(din), .conv_code(conv_code), .temp_code(temp_code), .dout(dout),
        .eoc_n(eoc_n), .chan_sel(chan_sel));

    sccc_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .got(got), .got_stb(got_stb));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic expect_word(input logic [15:0] w);
        exq.push_back({1'b0, w[15:8]});
        exq.push_back({1'b0, w[7:0]});
    endtask

    // fresh analog codes and the words they should read back as
    task automatic new_codes;
        @(posedge clk);
        seed = xs(seed);
        conv_code <= seed[9:0];
        temp_code <= seed[21:10];
        wc = {4'h0, seed[9:0], 2'h0};
        wt = {4'h0, seed[21:10]};
    endtask

    task automatic wait_eoc(input int lim);
        n = 0;
        while (eoc_n !== 1'b0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        check("eoc_n low", {7'h00, eoc_n}, 8'h00);
    endtask

    // takes the oldest note for every byte the host reads and compares the byte unless bit 8 of that note is set
    always @(posedge got_stb) begin
        if (exq.size() == 0) begin
            check("byte with no note", 8'h01, 8'h00);
        end else begin
            e = exq.pop_front();
            if (!e[8]) begin
                check("dout byte", got, e[7:0]);
            end
        end
    end

    initial begin
        #2000000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        new_codes();
        repeat (3) @(posedge clk);
        check("eoc_n reset", {7'h00, eoc_n}, 8'h01);
        check("chan_sel reset", {4'h0, chan_sel}, 8'h00);
        // select falls while the internal conversion waits on the reference
        exq.push_back(9'h000);
        host.frame(40'h8800000000, 8);
        #2000;
        expect_word(16'h0000);
        host.frame(40'h0, 16);
        repeat (2500) @(posedge clk);
        check("eoc_n after abort", {7'h00, eoc_n}, 8'h01);
        $display("test abort done");
        // default mode: temperature and conversion into the fifo, then cut-short reads
        new_codes();
        exq.push_back(9'h000);
        host.frame(40'h9900000000, 8);
        wait_eoc(3000);
        check("chan_sel", {4'h0, chan_sel}, 8'h03);
        repeat (50) @(posedge clk);
        check("eoc_n held", {7'h00, eoc_n}, 8'h00);
        host.frame(40'h0, 3);
        exq.push_back({1'b0, wt[12:5]});
        exq.push_back({1'b0, wc[15:8]});
        host.frame(40'h0, 19);
        exq.push_back(9'h000);
        host.frame(40'h0, 8);
        $display("test partial reads done");
        // four bits of a setup byte select the externally clocked mode
        host.frame(40'h7000000000, 4);
        new_codes();
        exq.push_back(9'h100);
        host.frame(40'ha800000000, 8);
        #65000;
        expect_word(wc);
        host.frame(40'h0, 16);
        check("chan_sel", {4'h0, chan_sel}, 8'h05);
        $display("test external conversion done");
        new_codes();
        exq.push_back(9'h100);
        host.frame(40'h8100000000, 8);
        #65000;
        repeat (22) exq.push_back(9'h000);
        expect_word(wt);
        host.frame(40'h0, 192);
        $display("test external temperature done");
        // full setup byte: external clock and external reference, so no wake wait is owed
        exq.push_back(9'h000);
        host.frame(40'h7400000000, 8);
        new_codes();
        // two conversions back to back, one zero byte between the command bytes
        exq.push_back(9'h000);
        expect_word(wc);
        expect_word(wc);
        host.frame(40'ha800b00000, 40);
        check("chan_sel chained", {4'h0, chan_sel}, 8'h06);
        $display("test chained conversions done");
        // full reset command restores the reset conversion byte
        exq.push_back(9'h000);
        host.frame(40'h1000000000, 8);
        check("chan_sel after reset command", {4'h0, chan_sel}, 8'h00);
        $display("test reset command done");
        check("queue drained", exq.size() == 0 ? 8'h00 : 8'h01, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
